/* test_tmec_event_compare.sv */
// Self-checking testbench for the event generation and compare control block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_tmec_event_compare;
  // ==========================================================================
  // Stimulus and model
  // ==========================================================================
  logic sys_clk = 1'b0, rstn = 1'b0, hwUpdate = 1'b0, hwTrigger = 1'b0, fet = 1'b0;
  tmec_pkg::tmec_bus_s bus = '0;
  tmec_pkg::tmec_cnt_s cnt = '0;
  logic [1:0] chanEnable = 2'h0, protectionLevel = 2'h0, cvWrEn = 2'h0;
  logic [15:0] cvWrData = 16'h0000, captureValue0, captureValue1, reloadValue, ctl = 16'h0000;
  logic [12:0] flagClear = 13'h0000, flagReg, fl;
  logic [31:0] rdata, d;
  logic [3:0] chanRequest;
  logic [1:0] preparedCompareOutput;
  logic counterReload, prescalerClear, trigRequest, po = 1'b0;
  int error_cnt = 0, n_compared = 0;
  int eb[6] = '{0, 1, 2, 3, 4, 6};
  int sm[14] = '{5, 0, 4, 1, 3, 2, 6, 6, 6, 6, 7, 7, 7, 7};
  int sc[14] = '{'h50, 'h100, 'h50, 'h100, 'h50, 'h100, 'h50, 'h150, 'h150, 'h50,
    'h50, 'h150, 'h150, 'h50};
  logic [13:0] sd = 14'h3300;
  always #50 sys_clk = ~sys_clk;
  tmec_event_compare DUT (.sys_clk, .rstn, .bus, .rdata, .cnt, .hwUpdate, .hwTrigger,
    .chanEnable, .protectionLevel, .filteredExternalTrigger(fet), .cvWrData, .cvWrEn,
    .flagClear, .flagReg, .captureValue0, .captureValue1, .counterReload, .reloadValue,
    .prescalerClear, .trigRequest, .chanRequest, .preparedCompareOutput);
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // The strobe stays up after a transfer so back-to-back calls never drive it twice
  // in one time step; callers drop it with bus = '0 before the bus idles.
  task automatic wr(logic [7:0] a, logic [31:0] v);
    bus = '{1'b1, 1'b0, a, v};
    cyc(1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    bus = '{1'b0, 1'b1, a, 32'h00000000};
    cyc(1);
    `CHK("rdata", e, rdata)
  endtask
  // Refused fields keep their old value; the lock uses the mode held before the write.
  function automatic logic [15:0] mctl(logic [15:0] o, logic [15:0] n);
    logic [15:0] r;
    r = n;
    for (int c = 0; c < 2; c++) begin
      if (chanEnable[c]) r[c*8 +: 2] = o[c*8 +: 2];
      if (protectionLevel == 2'h3 && o[c*8 +: 2] == 2'h0) r[c*8+4 +: 3] = o[c*8+4 +: 3];
    end
    return r;
  endfunction
  function automatic logic pm(int m, int c, bit dn, logic p);
    case (m)
      1: return (c == 'h100) ? 1'b1 : p;
      2: return (c == 'h100) ? 1'b0 : p;
      3: return (c == 'h100) ? !p : p;
      4: return 1'b0;
      5: return 1'b1;
      6: return dn ? !(c > 'h100) : (c < 'h100);
      7: return dn ? (c > 'h100) : !(c < 'h100);
      default: return p;
    endcase
  endfunction
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(32));
    cyc(8);
    rstn = 1'b1;
    cyc(1);
    rd(8'h18, 32'h0);
    rd(8'h14, 32'h0);
    // Counter and both compare values rest at zero, so both output channels match.
    `CHK("flags", 13'h006, flagReg)
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      protectionLevel = 2'($urandom);
      chanEnable = (protectionLevel == 2'h3) ? 2'h3 : 2'($urandom);
      d = $urandom;
      // Mode select 11 also needs a trigger source, chosen outside this block.
      wr(8'h18, d);
      ctl = mctl(ctl, d[15:0]);
      rd(8'h18, {16'h0, ctl});
    end
    $display("test control fields done");
    bus = '0;
    chanEnable = 2'h0;
    protectionLevel = 2'h0;
    cnt.count = 16'h1234;
    flagClear = '1;
    cyc(1);
    flagClear = '0;
    wr(8'h18, 32'h101);
    fl = 13'h0;
    repeat (2) foreach (eb[k]) begin
      cnt = {16'($urandom) | 16'h1, 1'($urandom), 16'($urandom)};
      wr(8'h14, 32'h1 << eb[k]);
      if (eb[k] inside {[1:2]} && fl[eb[k]]) fl[eb[k] + 8] = 1'b1;
      fl[eb[k]] = 1'b1;
      `CHK("reload", eb[k] == 0, counterReload)
      `CHK("pclr", eb[k] == 0, prescalerClear)
      `CHK("trig", eb[k] == 6, trigRequest)
      `CHK("chan", (eb[k] inside {[1:4]}) ? 4'h1 << (eb[k] - 1) : 4'h0, chanRequest)
      `CHK("flags", fl, flagReg)
      if (eb[k] == 0) `CHK("rval", cnt.countDown ? cnt.autoReload : 16'h0, reloadValue)
      if (eb[k] == 1) `CHK("cap0", cnt.count, captureValue0)
      if (eb[k] == 2) `CHK("cap1", cnt.count, captureValue1)
    end
    wr(8'h14, 32'h0);
    `CHK("zero", 1'b0, counterReload)
    bus = '0;
    flagClear = '1;
    cyc(1);
    flagClear = '0;
    hwUpdate = 1'b1;
    cyc(1);
    hwUpdate = 1'b0;
    `CHK("upflag", 13'h1, flagReg)
    $display("test events done");
    cvWrData = 16'h0200;
    cvWrEn = 2'h1;
    cyc(1);
    cvWrEn = 2'h0;
    cyc(1);
    `CHK("cv0", 16'h0200, captureValue0)
    wr(8'h18, 32'h8);
    bus = '0;
    cvWrData = 16'h0100;
    cvWrEn = 2'h1;
    cyc(1);
    cvWrEn = 2'h0;
    cyc(1);
    `CHK("cvsh", 16'h0200, captureValue0)
    hwUpdate = 1'b1;
    cyc(1);
    hwUpdate = 1'b0;
    cyc(1);
    `CHK("cvup", 16'h0100, captureValue0)
    for (int i = 0; i < 14; i++) begin
      cnt.countDown = sd[i];
      cnt.count = 16'h0EFF;
      wr(8'h18, 32'h0);
      wr(8'h18, sm[i] << 4);
      bus = '0;
      cnt.count = 16'(sc[i]);
      cyc(4);
      po = pm(sm[i], sc[i], sd[i], po);
      `CHK("out0", po, preparedCompareOutput[0])
    end
    // Counting up above the compare value keeps the pulse-width level low, so only
    // the trigger edge can raise it.
    cnt.countDown = 1'b0;
    cnt.count = 16'h0150;
    wr(8'h18, 32'h0);
    wr(8'h18, 32'h64);
    bus = '0;
    hwTrigger = 1'b1;
    cyc(1);
    hwTrigger = 1'b0;
    cyc(2);
    `CHK("fast0", 1'b1, preparedCompareOutput[0])
    wr(8'h18, 32'hD0D0);
    bus = '0;
    cyc(2);
    `CHK("frc", 2'h3, preparedCompareOutput)
    fet = 1'b1;
    cyc(4);
    `CHK("clr", 2'h0, preparedCompareOutput)
    fet = 1'b0;
    $display("test compare done");
    final_report();
  end
endmodule

/* tmec_event_compare.sv */
// Software event generation and output-compare channel control for channels 0 and 1.
`timescale 1ns/10ps
module tmec_event_compare #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk, // Timer clock, 10 MHz.
  input wire logic rstn, // Synchronous reset, active low.
  input wire tmec_pkg::tmec_bus_s bus, // Word register request.
  output logic [31:0] rdata, // Read data, registered.
  input wire tmec_pkg::tmec_cnt_s cnt, // Counter, direction, auto-reload.
  input wire logic hwUpdate, // Update event from the counter logic.
  input wire logic hwTrigger, // Active trigger edge from the slave controller.
  input wire logic [1:0] chanEnable, // Channel enables for channels 0 and 1.
  input wire logic [1:0] protectionLevel, // Protection field of the break register.
  input wire logic filteredExternalTrigger, // Filtered external trigger, async pin.
  input wire logic [15:0] cvWrData, // Compare value write data.
  input wire logic [1:0] cvWrEn, // Compare value write strobes per channel.
  input wire logic [12:0] flagClear, // Software clears of the flag register bits.
  output logic [12:0] flagReg, // Flag register bits 12..0, registered.
  output logic [15:0] captureValue0, // Channel 0 active compare/capture value.
  output logic [15:0] captureValue1, // Channel 1 active compare/capture value.
  output logic counterReload, // One-cycle pulse: load reloadValue into counter.
  output logic [15:0] reloadValue, // Value the counter loads on software update.
  output logic prescalerClear, // One-cycle pulse: clear prescaler counter.
  output logic trigRequest, // One-cycle pulse: trigger interrupt/DMA request.
  output logic [3:0] chanRequest, // One-cycle pulses: channel interrupt/DMA requests.
  output logic [1:0] preparedCompareOutput // Active-high prepared outputs ch1..ch0.
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    tmec_pkg::tmec_chan_s [1:0] chan;
    logic [1:0][15:0] cvShadow;
    logic [1:0][15:0] cvActive;
    logic [1:0] prep;
    logic [1:0] cmpLast;
    logic [12:0] flags;
    logic [1:0] etrSync;
    logic upPulse;
    logic trgPulse;
    logic [3:0] chPulse;
    logic [15:0] reload;
    logic [31:0] rdata;
  } tmec_state_s;

  tmec_state_s state_q;
  tmec_state_s state_d;

  // Unpack one channel's control byte.
  function automatic tmec_pkg::tmec_chan_s unpackChan(input logic [7:0] b);
    tmec_pkg::tmec_chan_s c;
    c.clearEn = b[tmec_pkg::CEN_BIT];
    c.cmpMode = tmec_pkg::tmec_cmp_e'(b[tmec_pkg::MODE_LSB +: 3]);
    c.shadowEn = b[tmec_pkg::SEN_BIT];
    c.fastEn = b[tmec_pkg::FEN_BIT];
    c.modeSel = b[tmec_pkg::MS_LSB +: 2];
    return c;
  endfunction

  // PWM comparison level for one channel.
  function automatic logic pwmLevel(input tmec_pkg::tmec_cmp_e m, input logic down,
                                    input logic [15:0] count, input logic [15:0] cv);
    logic lvl;
    lvl = down ? !(count > cv) : (count < cv);
    if (m == tmec_pkg::CMP_PWM1) begin
      lvl = !lvl;
    end
    return lvl;
  endfunction

  always_comb begin
    tmec_pkg::tmec_chan_s nc;
    logic wrSw;
    logic wrCtl;
    logic [4:0] gen;
    logic anyUpdate;
    logic match;
    logic pwm;
    logic lvl;
    nc = '0;
    match = 1'b0;
    pwm = 1'b0;
    lvl = 1'b0;
    state_d = state_q;
    wrSw = bus.wrEn && (bus.addr == tmec_pkg::SWEVG_OFFSET);
    wrCtl = bus.wrEn && (bus.addr == tmec_pkg::CHCTL0_OFFSET);
    // Only ones act; zeros are no-ops, pulses last one cycle.
    gen = wrSw ? bus.wdata[4:0] : 5'h00;
    state_d.upPulse = gen[tmec_pkg::UPG_BIT];
    state_d.trgPulse = wrSw && bus.wdata[tmec_pkg::TRIGGER_EVENT_GENERATE_BIT];
    state_d.chPulse = gen[4:1];
    state_d.reload = cnt.countDown ? cnt.autoReload : 16'h0000;
    anyUpdate = hwUpdate || gen[tmec_pkg::UPG_BIT];
    state_d.etrSync = {state_q.etrSync[0], filteredExternalTrigger};

    // Flags: hardware set wins over a same-cycle clear.
    state_d.flags = state_q.flags & ~flagClear;
    if (anyUpdate) begin
      state_d.flags[tmec_pkg::UPDATE_FLAG_BIT] = 1'b1;
    end
    if (state_d.trgPulse || hwTrigger) begin
      state_d.flags[tmec_pkg::TRIGGER_FLAG_BIT] = 1'b1;
    end

    // Control register writes with mode-select and protection locks.
    for (int i = 0; i < 2; i++) begin
      if (wrCtl) begin
        nc = unpackChan(bus.wdata[i*tmec_pkg::CH_STRIDE +: 8]);
        state_d.chan[i].clearEn = nc.clearEn;
        state_d.chan[i].shadowEn = nc.shadowEn;
        state_d.chan[i].fastEn = nc.fastEn;
        if (!chanEnable[i]) begin
          state_d.chan[i].modeSel = nc.modeSel;
        end
        if (!(protectionLevel == tmec_pkg::PROTECTION_LEVEL_LOCKED &&
              state_q.chan[i].modeSel == tmec_pkg::MS_OUTPUT)) begin
          state_d.chan[i].cmpMode = nc.cmpMode;
        end
      end
      // Compare value writes go to shadow when enabled.
      if (cvWrEn[i]) begin
        state_d.cvShadow[i] = cvWrData;
        if (!state_q.chan[i].shadowEn) begin
          state_d.cvActive[i] = cvWrData;
        end
      end
      if (anyUpdate && state_q.chan[i].shadowEn) begin
        state_d.cvActive[i] = cvWrEn[i] ? cvWrData : state_q.cvShadow[i];
      end
      // Software capture on an input-mode channel.
      if (gen[1+i] && state_q.chan[i].modeSel != tmec_pkg::MS_OUTPUT) begin
        state_d.cvActive[i] = cnt.count;
        if (state_q.flags[tmec_pkg::CHIF_LSB+i]) begin
          state_d.flags[tmec_pkg::CHOF_LSB+i] = 1'b1;
        end
      end

      // Prepared output, active high; pin polarity is applied downstream.
      match = (cnt.count == state_q.cvActive[i]);
      pwm = state_q.chan[i].cmpMode inside {tmec_pkg::CMP_PWM0, tmec_pkg::CMP_PWM1};
      lvl = pwmLevel(state_q.chan[i].cmpMode, cnt.countDown, cnt.count, state_q.cvActive[i]);
      // Keep the raw comparison, not the level, so a switch between the two
      // pulse-width senses cannot look like a change of the comparison.
      state_d.cmpLast[i] = pwmLevel(tmec_pkg::CMP_PWM0, cnt.countDown, cnt.count,
                                    state_q.cvActive[i]);
      if (state_q.chan[i].modeSel == tmec_pkg::MS_OUTPUT && match) begin
        state_d.flags[tmec_pkg::CHIF_LSB+i] = 1'b1;
      end
      case (state_q.chan[i].cmpMode)
        tmec_pkg::CMP_TIMING: state_d.prep[i] = state_q.prep[i];
        tmec_pkg::CMP_SET: if (match) state_d.prep[i] = 1'b1;
        tmec_pkg::CMP_CLEAR: if (match) state_d.prep[i] = 1'b0;
        tmec_pkg::CMP_TOGGLE: if (match) state_d.prep[i] = !state_q.prep[i];
        tmec_pkg::CMP_FORCE_LOW: state_d.prep[i] = 1'b0;
        tmec_pkg::CMP_FORCE_HIGH: state_d.prep[i] = 1'b1;
        tmec_pkg::CMP_PWM0, tmec_pkg::CMP_PWM1: begin
          // Follow the comparison only when it changes or when a control write changes the mode.
          if ((state_d.cmpLast[i] != state_q.cmpLast[i]) ||
              (state_q.chan[i].cmpMode != state_d.chan[i].cmpMode)) begin
            state_d.prep[i] = lvl;
          end
        end
        default: state_d.prep[i] = state_q.prep[i];
      endcase
      if (wrCtl && state_q.chan[i].cmpMode == tmec_pkg::CMP_TIMING &&
          state_d.chan[i].cmpMode inside {tmec_pkg::CMP_PWM0, tmec_pkg::CMP_PWM1}) begin
        state_d.prep[i] = pwmLevel(state_d.chan[i].cmpMode, cnt.countDown, cnt.count,
                                   state_q.cvActive[i]);
      end
      // Fast mode: in the two PWM modes a trigger edge acts as a match at once.
      if (pwm && state_q.chan[i].fastEn && hwTrigger) begin
        state_d.prep[i] = (state_q.chan[i].cmpMode == tmec_pkg::CMP_PWM0);
      end
      // External clear overrides everything while the trigger is high.
      if (state_q.chan[i].clearEn && state_q.etrSync[1]) begin
        state_d.prep[i] = 1'b0;
      end
    end
    // Channel generate bits set every channel flag, capture or compare.
    state_d.flags[tmec_pkg::CHIF_LSB +: 4] = state_d.flags[tmec_pkg::CHIF_LSB +: 4] | gen[4:1];

    // Register readback; generate bits always read as zero.
    state_d.rdata = 32'h00000000;
    if (bus.rdEn && bus.addr == tmec_pkg::CHCTL0_OFFSET) begin
      for (int i = 0; i < 2; i++) begin
        state_d.rdata[i*tmec_pkg::CH_STRIDE +: 8] = {state_q.chan[i].clearEn,
          state_q.chan[i].cmpMode, state_q.chan[i].shadowEn, state_q.chan[i].fastEn,
          state_q.chan[i].modeSel};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
  assign flagReg = state_q.flags;
  assign captureValue0 = state_q.cvActive[0];
  assign captureValue1 = state_q.cvActive[1];
  assign counterReload = state_q.upPulse;
  assign reloadValue = state_q.reload;
  assign prescalerClear = state_q.upPulse;
  assign trigRequest = state_q.trgPulse;
  assign chanRequest = state_q.chPulse;
  assign preparedCompareOutput = state_q.prep;
endmodule

/* tmec_event_compare_chk.sv */
// Port-level checker for the event generation and compare control block.
`timescale 1ns/10ps
module tmec_event_compare_chk (
  input wire logic sys_clk, // Timer clock.
  input wire logic rstn, // Reset, active low.
  input wire tmec_pkg::tmec_bus_s bus, // Register request.
  input wire logic [31:0] rdata, // Read data.
  input wire tmec_pkg::tmec_cnt_s cnt, // Counter view.
  input wire logic hwUpdate, // Update event.
  input wire logic [12:0] flagClear, // Flag clears.
  input wire logic [12:0] flagReg, // Flags.
  input wire logic counterReload, // Reload pulse.
  input wire logic [15:0] reloadValue, // Reload value.
  input wire logic prescalerClear, // Prescaler clear pulse.
  input wire logic trigRequest, // Trigger request pulse.
  input wire logic [3:0] chanRequest // Channel request pulses.
);
  // ==========================================================================
  // Event generation
  // ==========================================================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence evWr(int b);
    bus.wrEn && bus.addr == tmec_pkg::SWEVG_OFFSET && bus.wdata[b];
  endsequence
  upd_reload_a: assert property (evWr(0) |=> counterReload && prescalerClear)
    else $error("update write gave no reload pulse");
  reload_val_a: assert property (evWr(0) |=> reloadValue ==
    ($past(cnt.countDown) ? $past(cnt.autoReload) : 16'h0000)) else $error("bad reload value");
  trig_flag_a: assert property (evWr(6) |=> trigRequest && flagReg[6])
    else $error("trigger write gave no flag or request");
  chan_flag_a: assert property (evWr(1) |=> chanRequest[0] && flagReg[1])
    else $error("channel write gave no flag or request");
  trig_clear_a: assert property (trigRequest &&
    !(bus.wrEn && bus.addr == tmec_pkg::SWEVG_OFFSET && bus.wdata[6]) |=> !trigRequest)
    else $error("trigger request did not clear");
  upd_flag_a: assert property (hwUpdate |=> flagReg[0])
    else $error("update event did not set flag");
  flag_hold_a: assert property (flagReg[0] && !flagClear[0] |=> flagReg[0])
    else $error("update flag dropped without clear");
  zero_write_a: assert property (bus.wrEn && bus.addr == tmec_pkg::SWEVG_OFFSET &&
    bus.wdata == 32'h00000000 && !hwUpdate |=> !counterReload && !prescalerClear)
    else $error("zero write had an effect");
  evg_read_a: assert property (bus.rdEn && bus.addr == tmec_pkg::SWEVG_OFFSET |=>
    rdata == 32'h00000000) else $error("event register read nonzero");
endmodule
bind tmec_event_compare tmec_event_compare_chk u_chk (.sys_clk, .rstn, .bus, .rdata, .cnt,
  .hwUpdate, .flagClear, .flagReg, .counterReload, .reloadValue, .prescalerClear,
  .trigRequest, .chanRequest);

/* tmec_pkg.sv */
// Package with offsets, field positions, reset values and carrier types for the event/compare block.
package tmec_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] SWEVG_OFFSET = 8'h14;
  localparam logic [7:0] CHCTL0_OFFSET = 8'h18;
  localparam logic [31:0] SWEVG_RESET = 32'h00000000;
  localparam logic [31:0] CHCTL0_RESET = 32'h00000000;
  // Event generation bits.
  localparam int UPG_BIT = 0;
  localparam int CHAN0_EVENT_GENERATE_BIT = 1;
  localparam int TRIGGER_EVENT_GENERATE_BIT = 6;
  // Channel control fields, channel 0 base; channel 1 adds CH_STRIDE.
  localparam int CH_STRIDE = 8;
  localparam int MS_LSB = 0;
  localparam int FEN_BIT = 2;
  localparam int SEN_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int CEN_BIT = 7;
  // Flag register bit positions used on the flag outputs.
  localparam int UPDATE_FLAG_BIT = 0;
  localparam int CHIF_LSB = 1;
  localparam int TRIGGER_FLAG_BIT = 6;
  localparam int CHOF_LSB = 9;
  localparam logic [1:0] PROTECTION_LEVEL_LOCKED = 2'h3;
  localparam logic [1:0] MS_OUTPUT = 2'h0;
  localparam logic [1:0] MS_ITS = 2'h3;
  localparam logic [12:0] FLAG_RESET = 13'h0000;
  localparam logic [15:0] CV_RESET = 16'h0000;

  typedef enum logic [2:0] {
    CMP_TIMING = 3'h0,
    CMP_SET = 3'h1,
    CMP_CLEAR = 3'h2,
    CMP_TOGGLE = 3'h3,
    CMP_FORCE_LOW = 3'h4,
    CMP_FORCE_HIGH = 3'h5,
    CMP_PWM0 = 3'h6,
    CMP_PWM1 = 3'h7
  } tmec_cmp_e;

  typedef struct packed {
    logic clearEn;
    tmec_cmp_e cmpMode;
    logic shadowEn;
    logic fastEn;
    logic [1:0] modeSel;
  } tmec_chan_s;

  // Register bus request carrier.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tmec_bus_s;

  // Counter-side view from the rest of the timer.
  typedef struct packed {
    logic [15:0] count;
    logic countDown;
    logic [15:0] autoReload;
  } tmec_cnt_s;
endpackage
